// ===== hdl/lcd_instruction_decoder_pkg.sv
// Package of constants and types for the display instruction decoder
package lcd_instruction_decoder_pkg;

  localparam int unsigned CLK_HZ          = 125_000_000;
  localparam int unsigned OSC_HZ          = 270_000;
  localparam int unsigned EXEC_US         = 39;
  localparam int unsigned BLINK_MS        = 370;
  // Base execution time in core cycles, rounded down
  localparam int unsigned EXEC_CYCLES     = (EXEC_US * (CLK_HZ / 1_000_000));
  // Half period of the inversion blink, rounded down
  localparam int unsigned BLINK_HALF_CYC  = (BLINK_MS * (CLK_HZ / 1_000)) / 2;
  localparam logic [5:0]  SQ_MAX          = 6'h30;
  localparam logic [6:0]  ONE_LINE_LAST   = 7'h4f;
  localparam logic [6:0]  TWO_LINE_LAST   = 7'h27;
  localparam logic [6:0]  TWO_LINE_SECOND = 7'h40;
  localparam logic [6:0]  FOUR_LINE_LAST  = 7'h13;
  localparam logic [1:0]  ONE_LINE_DIV    = 2'h3;
  localparam logic [1:0]  OTHER_DIV       = 2'h1;

  typedef enum logic [1:0] {
    RAM_DISPLAY = 2'h0,
    RAM_GLYPH   = 2'h1,
    RAM_ICON    = 2'h2
  } ram_sel_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_EXEC = 2'b01,
    ST_DONE = 2'b11
  } exec_state_t;

  typedef struct packed {
    logic font_width_sel;
    logic cursor_invert_en;
    logic four_line_en;
    logic two_line_sel;
    logic bus_width_sel;
    logic extension_gate;
    logic glyph_blink_en;
    logic low_power_en;
  } mode_t;

  typedef struct packed {
    logic [3:0] line_scroll_en;
    logic [5:0] scroll_quantity;
    logic [5:0] scroll_dots;
  } scroll_t;

  localparam mode_t MODE_RESET = '{bus_width_sel: 1'b1, two_line_sel: 1'b1, default: 1'b0};

endpackage

// ===== hdl/lcd_instruction_decoder.sv
// Instruction decoder for extended and address-setting display commands
// Summary of operation
// - Font width flag selects six-dot glyphs and stretches execution by six fifths.
// - Six-dot mode shows glyph RAM rows using bits five down to zero.
// - Inversion flag toggles cursor character every 185 ms, overriding cursor controls.
// - Four-line flag selects four lines and ignores the line-count bit.
// - Shift: 00 cursor left dec, 01 cursor right inc, 10/11 display shift.
// - Two-line mode: cursor wraps to second line after 40th position.
// - Four-line mode: cursor moves to next line after each 20th position.
// - Display shift applies to all lines and keeps address counter.
// - Scroll enable carries four per-line bits; host pairs them per line.
// - Bus-width bit picks 8-bit when high, 4-bit nibble pairs when low.
// - Line-count bit applies only without four-line flag: low one, high two.
// - Extension gate enables extended set, icon address, scroll enables and blink.
// - Blink enable blinks glyph and icon entries per their top two bits.
// - Low power without expander divides clock by four one-line, two otherwise.
// - Low power without expander lowers frame frequency to five sixths of normal.
// - Glyph address instruction loads six bits and selects glyph RAM.
// - Icon address instruction loads four bits and selects icon RAM.
// - Display address loads seven bits; one-line range 00h to 4fh.
// - Two-line mode lines span 00h-27h and 40h-67h.
// - Four-line mode lines span 00h-13h, 20h-33h, 40h-53h, 60h-73h.
// - Scroll quantity zero none, up to 47 dots, top bits set 48.
// - Busy flag reports execution; host waits for it before next instruction.
// - Address-setting instructions complete in 39 us at nominal oscillator.
`timescale 1ns/1ps
module lcd_instruction_decoder (
  input  wire logic                                  core_clk_i,
  input  wire logic                                  reset_i,
  input  wire logic                                  instr_valid_i,
  input  wire logic [7:0]                            instr_i,
  input  wire logic                                  expander_present_i,
  input  wire logic                                  cursor_inc_i,
  output logic                                       busy_flag_o,
  output logic [6:0]                                 address_counter_o,
  output lcd_instruction_decoder_pkg::ram_sel_t      ram_sel_o,
  output lcd_instruction_decoder_pkg::mode_t         mode_o,
  output lcd_instruction_decoder_pkg::scroll_t       scroll_o,
  output logic                                       glyph_six_dot_o,
  output logic                                       invert_phase_o,
  output logic [1:0]                                 clock_div_o,
  output logic                                       frame_five_sixths_o,
  output logic                                       display_shift_o,
  output logic                                       display_shift_right_o,
  output logic                                       address_error_o
);

  lcd_instruction_decoder_pkg::exec_state_t state;
  lcd_instruction_decoder_pkg::mode_t       mode;
  lcd_instruction_decoder_pkg::scroll_t     scroll;
  logic [31:0]                              exec_count;
  logic [31:0]                              exec_target;
  logic [31:0]                              blink_count;
  logic                                     take;
  logic                                     is_func;
  logic                                     is_shift;
  logic                                     is_aux;
  logic                                     is_glyph;
  logic                                     is_display;
  logic                                     dd_ok;
  logic [6:0]                               next_shift_addr;
  logic [1:0]                               div_factor;
  logic                                     expander_meta;
  logic                                     expander_mid;
  logic                                     expander_last;
  logic                                     expander_seen;

  // Only accepted while idle
  assign take       = instr_valid_i && (state == lcd_instruction_decoder_pkg::ST_IDLE);
  assign is_func    = (instr_i[7:5] == 3'b001);
  assign is_shift   = (instr_i[7:4] == 4'b0001);
  assign is_aux     = (instr_i[7:3] == 5'b00001);
  assign is_glyph   = (instr_i[7:6] == 2'b01);
  assign is_display = instr_i[7];

  // Expander pin synchroniser and agreement filter
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      expander_meta <= 1'b0;
      expander_mid  <= 1'b0;
      expander_last <= 1'b0;
      expander_seen <= 1'b0;
    end else begin
      expander_meta <= expander_present_i;
      expander_mid  <= expander_meta;
      expander_last <= expander_mid;
      if (expander_mid == expander_last) begin
        expander_seen <= expander_last;
      end
    end
  end

  always_comb begin
    if (mode.low_power_en && !expander_seen) begin
      div_factor = (!mode.four_line_en && !mode.two_line_sel) ? lcd_instruction_decoder_pkg::ONE_LINE_DIV
                                                             : lcd_instruction_decoder_pkg::OTHER_DIV;
    end else begin
      div_factor = 2'h0;
    end
  end

  always_comb begin
    exec_target = lcd_instruction_decoder_pkg::EXEC_CYCLES;
    if (mode.font_width_sel) begin
      exec_target = (lcd_instruction_decoder_pkg::EXEC_CYCLES * 6) / 5;
    end
    exec_target = exec_target * ({30'h0, div_factor} + 32'h1);
  end

  // display address validity per line mode
  always_comb begin
    dd_ok = 1'b0;
    if (mode.four_line_en) begin
      dd_ok = (instr_i[4:0] <= lcd_instruction_decoder_pkg::FOUR_LINE_LAST[4:0]);
    end else if (mode.two_line_sel) begin
      dd_ok = (instr_i[5:0] <= lcd_instruction_decoder_pkg::TWO_LINE_LAST[5:0]);
    end else begin
      dd_ok = (instr_i[6:0] <= lcd_instruction_decoder_pkg::ONE_LINE_LAST);
    end
  end

  // cursor wrap in two-line; four-line; step direction
  always_comb begin
    next_shift_addr = address_counter_o;
    if (instr_i[2]) begin
      if (mode.four_line_en && address_counter_o[4:0] == lcd_instruction_decoder_pkg::FOUR_LINE_LAST[4:0]) begin
        next_shift_addr = {address_counter_o[6:5] + 2'h1, 5'h00};
      end else if (!mode.four_line_en && mode.two_line_sel &&
                   address_counter_o == lcd_instruction_decoder_pkg::TWO_LINE_LAST) begin
        next_shift_addr = lcd_instruction_decoder_pkg::TWO_LINE_SECOND;
      end else begin
        next_shift_addr = address_counter_o + 7'h01;
      end
    end else begin
      next_shift_addr = address_counter_o - 7'h01;
    end
  end

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      state      <= lcd_instruction_decoder_pkg::ST_IDLE;
      exec_count <= 32'h0;
    end else begin
      case (state)
        lcd_instruction_decoder_pkg::ST_IDLE: begin
          exec_count <= 32'h0;
          if (take) begin
            state <= lcd_instruction_decoder_pkg::ST_EXEC;
          end
        end
        lcd_instruction_decoder_pkg::ST_EXEC: begin
          exec_count <= exec_count + 32'h1;
          if (exec_count + 32'h2 >= exec_target) begin
            state <= lcd_instruction_decoder_pkg::ST_DONE;
          end
        end
        lcd_instruction_decoder_pkg::ST_DONE: begin
          state <= lcd_instruction_decoder_pkg::ST_IDLE;
        end
        default: begin
          state <= lcd_instruction_decoder_pkg::ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      busy_flag_o <= 1'b1;
    end else begin
      busy_flag_o <= take || (state == lcd_instruction_decoder_pkg::ST_EXEC);
    end
  end

  // Mode register updates
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      mode <= lcd_instruction_decoder_pkg::MODE_RESET;
    end else if (take) begin
      if (is_func) begin
        mode.bus_width_sel  <= instr_i[4];
        mode.two_line_sel   <= instr_i[3];
        mode.extension_gate <= instr_i[2];
        // blink and low power only with gate set
        if (instr_i[2]) begin
          mode.glyph_blink_en <= instr_i[1];
          mode.low_power_en   <= instr_i[0];
        end
      end else if (is_aux && mode.extension_gate) begin
        mode.font_width_sel   <= instr_i[2];
        mode.cursor_invert_en <= instr_i[1];
        mode.four_line_en     <= instr_i[0];
      end
    end
  end

  // Scroll registers
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      scroll <= '0;
    end else if (take && mode.extension_gate) begin
      if (is_shift) begin
        scroll.line_scroll_en <= instr_i[3:0];
      end
      if (is_display) begin
        scroll.scroll_quantity <= instr_i[5:0];
        scroll.scroll_dots     <= (instr_i[5:4] == 2'b11) ? lcd_instruction_decoder_pkg::SQ_MAX : instr_i[5:0];
      end
    end
  end

  // Address counter and RAM target
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      address_counter_o     <= 7'h00;
      ram_sel_o             <= lcd_instruction_decoder_pkg::RAM_DISPLAY;
      display_shift_o       <= 1'b0;
      display_shift_right_o <= 1'b0;
      address_error_o       <= 1'b0;
    end else begin
      display_shift_o <= 1'b0;
      if (take) begin
        if (is_shift && !mode.extension_gate) begin
          if (instr_i[3]) begin
            display_shift_o       <= 1'b1;
            display_shift_right_o <= instr_i[2];
          end else begin
            address_counter_o <= next_shift_addr;
          end
        end else if (is_glyph) begin
          if (mode.extension_gate) begin
            address_counter_o <= {3'h0, instr_i[3:0]};
            ram_sel_o         <= lcd_instruction_decoder_pkg::RAM_ICON;
          end else begin
            address_counter_o <= {1'b0, instr_i[5:0]};
            ram_sel_o         <= lcd_instruction_decoder_pkg::RAM_GLYPH;
          end
        end else if (is_display && !mode.extension_gate) begin
          address_counter_o <= instr_i[6:0];
          ram_sel_o         <= lcd_instruction_decoder_pkg::RAM_DISPLAY;
          address_error_o   <= !dd_ok;
        end
      end
    end
  end

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      blink_count    <= 32'h0;
      invert_phase_o <= 1'b0;
    end else if (!mode.cursor_invert_en) begin
      blink_count    <= 32'h0;
      invert_phase_o <= 1'b0;
    end else if (blink_count + 32'h1 >= lcd_instruction_decoder_pkg::BLINK_HALF_CYC) begin
      blink_count    <= 32'h0;
      invert_phase_o <= !invert_phase_o;
    end else begin
      blink_count <= blink_count + 32'h1;
    end
  end

  // Registered mode outputs
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      mode_o              <= lcd_instruction_decoder_pkg::MODE_RESET;
      scroll_o            <= '0;
      glyph_six_dot_o     <= 1'b0;
      clock_div_o         <= 2'h0;
      frame_five_sixths_o <= 1'b0;
    end else begin
      mode_o              <= mode;
      scroll_o            <= scroll;
      glyph_six_dot_o     <= mode.font_width_sel;
      clock_div_o         <= div_factor;
      frame_five_sixths_o <= mode.low_power_en && !expander_seen;
    end
  end

  a_busy_exec: assert property (@(posedge core_clk_i) disable iff (reset_i)
    (state == lcd_instruction_decoder_pkg::ST_EXEC) |=> busy_flag_o) else $error("busy low during execution");

  a_glyph_load: assert property (@(posedge core_clk_i) disable iff (reset_i)
    (take && is_glyph && !mode.extension_gate) |=> (address_counter_o == {1'b0, $past(instr_i[5:0])}
      && ram_sel_o == lcd_instruction_decoder_pkg::RAM_GLYPH)) else $error("glyph address not loaded");

  a_icon_load: assert property (@(posedge core_clk_i) disable iff (reset_i)
    (take && is_glyph && mode.extension_gate) |=> (ram_sel_o == lcd_instruction_decoder_pkg::RAM_ICON
      && address_counter_o[6:4] == 3'h0)) else $error("icon address not loaded");

  a_shift_keep: assert property (@(posedge core_clk_i) disable iff (reset_i)
    (take && is_shift && !mode.extension_gate && instr_i[3]) |=> $stable(address_counter_o))
    else $error("display shift moved address");

  a_scroll_sat: assert property (@(posedge core_clk_i) disable iff (reset_i)
    scroll.scroll_dots <= lcd_instruction_decoder_pkg::SQ_MAX) else $error("scroll beyond 48 dots");

  a_gate_block: assert property (@(posedge core_clk_i) disable iff (reset_i)
    (take && is_aux && !mode.extension_gate) |=> $stable(mode.four_line_en)) else $error("extended set without gate");

  a_cursor_inc: assert property (@(posedge core_clk_i) disable iff (reset_i)
    (take && is_shift && !mode.extension_gate && instr_i[3:2] == 2'b01 && !mode.four_line_en && !mode.two_line_sel)
      |=> address_counter_o == $past(address_counter_o) + 7'h01) else $error("cursor right step wrong");

  // one-line low power divide by four
  a_div_four: assert property (@(posedge core_clk_i) disable iff (reset_i)
    (mode.low_power_en && !expander_seen && !mode.four_line_en && !mode.two_line_sel)
      |=> clock_div_o == lcd_instruction_decoder_pkg::ONE_LINE_DIV) else $error("clock divide wrong");

  a_display_load: assert property (@(posedge core_clk_i) disable iff (reset_i)
    (take && is_display && !mode.extension_gate) |=> (address_counter_o == $past(instr_i[6:0])
      && ram_sel_o == lcd_instruction_decoder_pkg::RAM_DISPLAY)) else $error("display address not loaded");

  sequence s_shift_request;
    take && is_shift && !mode.extension_gate && instr_i[3];
  endsequence

  sequence s_shift_pulse;
    display_shift_o ##1 !display_shift_o;
  endsequence

  a_shift_pulse: assert property (@(posedge core_clk_i) disable iff (reset_i)
    s_shift_request |=> s_shift_pulse) else $error("display shift pulse wrong");

endmodule

// ===== tb/host_bus_model.sv
// Host model that issues instruction bytes and honours the busy flag
`timescale 1ns/1ps
module host_bus_model (
  input  wire logic       core_clk_i,
  input  wire logic       busy_flag_i,
  output logic            instr_valid_o,
  output logic [7:0]      instr_o
);
  initial begin
    instr_valid_o = 1'b0;
    instr_o       = 8'h00;
  end

  task automatic send(input logic [7:0] b, output int cyc);
    int guard;
    guard = 0;
    // wait for idle before a strobe
    while (busy_flag_i !== 1'b0 && guard < 30000) begin
      @(posedge core_clk_i);
      #1;
      guard++;
    end
    @(posedge core_clk_i);
    instr_valid_o <= 1'b1;
    instr_o       <= b;
    @(posedge core_clk_i);
    instr_valid_o <= 1'b0;
    instr_o       <= ~b;
    cyc = 0;
    do begin
      @(posedge core_clk_i);
      #1;
      cyc++;
    end while (busy_flag_i === 1'b1 && cyc < 30000);
  endtask
endmodule

// ===== tb/lcd_instruction_decoder_tb_top.sv
// Self-checking bench for the display instruction decoder
`timescale 1ns/1ps
module lcd_instruction_decoder_tb_top;
  localparam int E = lcd_instruction_decoder_pkg::EXEC_CYCLES;
  logic                                  core_clk_i;
  logic                                  reset_i;
  logic                                  instr_valid_i;
  logic [7:0]                            instr_i;
  logic                                  expander_present_i;
  logic                                  cursor_inc_i;
  logic                                  busy_flag_o;
  logic [6:0]                            address_counter_o;
  lcd_instruction_decoder_pkg::ram_sel_t ram_sel_o;
  lcd_instruction_decoder_pkg::mode_t    mode_o;
  lcd_instruction_decoder_pkg::scroll_t  scroll_o;
  logic                                  glyph_six_dot_o;
  logic                                  frame_five_sixths_o;
  logic                                  display_shift_right_o;
  logic                                  display_shift_o;
  logic                                  invert_phase_o;
  int                                    n_shift;
  logic                                  address_error_o;
  logic [1:0]                            clock_div_o;
  int                                    err_total;
  int                                    n_checks;
  int                                    ticks;
  int                                    c;

  lcd_instruction_decoder dut (
    .core_clk_i(core_clk_i), .reset_i(reset_i), .instr_valid_i(instr_valid_i), .instr_i(instr_i),
    .expander_present_i(expander_present_i), .cursor_inc_i(cursor_inc_i), .busy_flag_o(busy_flag_o),
    .address_counter_o(address_counter_o), .ram_sel_o(ram_sel_o), .mode_o(mode_o), .scroll_o(scroll_o),
    .glyph_six_dot_o(glyph_six_dot_o), .invert_phase_o(invert_phase_o), .clock_div_o(clock_div_o),
    .frame_five_sixths_o(frame_five_sixths_o), .display_shift_o(display_shift_o),
    .display_shift_right_o(display_shift_right_o), .address_error_o(address_error_o)
  );

  host_bus_model u_host (
    .core_clk_i(core_clk_i), .busy_flag_i(busy_flag_o), .instr_valid_o(instr_valid_i), .instr_o(instr_i)
  );

  initial begin
    core_clk_i = 1'b0;
    forever #4 core_clk_i = ~core_clk_i;
  end

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic busy_len(input int cyc, input int exp);
    chk("busy_len", {31'h0, (cyc >= exp - 8 && cyc <= exp + 8)}, 32'h1);
  endtask

  task automatic report_and_stop();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic t_reset();
    repeat (20) @(posedge core_clk_i);
    chk("busy_in_reset", busy_flag_o, 1);
    chk("mode_reset", mode_o, lcd_instruction_decoder_pkg::MODE_RESET);
    chk("addr_reset", address_counter_o, 0);
    reset_i <= 1'b0;
    @(posedge core_clk_i);
    #1;
    chk("busy_after_reset", busy_flag_o, 0);
  endtask

  task automatic t_two_line();
    u_host.send(8'ha7, c);
    chk("addr", address_counter_o, 7'h27);
    chk("ram_sel", ram_sel_o, lcd_instruction_decoder_pkg::RAM_DISPLAY);
    chk("addr_err", address_error_o, 0);
    busy_len(c, E);
    u_host.send(8'h14, c);
    chk("addr_wrap", address_counter_o, 7'h40);
  endtask

  task automatic t_glyph();
    u_host.send(8'h7f, c);
    chk("addr", address_counter_o, 7'h3f);
    chk("ram_sel", ram_sel_o, lcd_instruction_decoder_pkg::RAM_GLYPH);
    u_host.send(8'h10, c);
    chk("addr_dec", address_counter_o, 7'h3e);
  endtask

  task automatic t_extended();
    u_host.send(8'h3c, c);
    chk("gate", mode_o.extension_gate, 1);
    u_host.send(8'h4a, c);
    chk("addr", address_counter_o, 7'h0a);
    chk("ram_sel", ram_sel_o, lcd_instruction_decoder_pkg::RAM_ICON);
    u_host.send(8'h13, c);
    chk("line_scroll", scroll_o.line_scroll_en, 4'h3);
    u_host.send(8'hba, c);
    chk("sq_raw", scroll_o.scroll_quantity, 6'h3a);
    chk("sq_dots", scroll_o.scroll_dots, 6'h30);
    u_host.send(8'h0d, c);
    chk("four_line", mode_o.four_line_en, 1);
    chk("font_width", mode_o.font_width_sel, 1);
    chk("invert", mode_o.cursor_invert_en, 0);
    chk("six_dot", glyph_six_dot_o, 1);
    chk("invert_phase", invert_phase_o, 0);
  endtask

  task automatic t_four_line();
    u_host.send(8'h38, c);
    chk("four_line_kept", mode_o.four_line_en, 1);
    chk("gate_clear", mode_o.extension_gate, 0);
    busy_len(c, E * 6 / 5);
    u_host.send(8'h94, c);
    chk("addr_err", address_error_o, 1);
    u_host.send(8'h93, c);
    chk("addr_err", address_error_o, 0);
    u_host.send(8'h14, c);
    chk("addr_next_line", address_counter_o, 7'h20);
    u_host.send(8'h1c, c);
    chk("addr_kept", address_counter_o, 7'h20);
    chk("shift_right", display_shift_right_o, 1);
    chk("shift_pulses", n_shift, 1);
  endtask

  task automatic t_low_power();
    u_host.send(8'h2f, c);
    chk("bus_width", mode_o.bus_width_sel, 0);
    chk("blink_en", mode_o.glyph_blink_en, 1);
    chk("div_with_expander", clock_div_o, 2'h0);
    @(posedge core_clk_i);
    expander_present_i <= 1'b0;
    repeat (6) @(posedge core_clk_i);
    #1;
    chk("div_low_power", clock_div_o, lcd_instruction_decoder_pkg::OTHER_DIV);
    chk("frame_rate", frame_five_sixths_o, 1);
    @(posedge core_clk_i);
    expander_present_i <= 1'b1;
    repeat (6) @(posedge core_clk_i);
    u_host.send(8'h08, c);
    chk("four_line_off", mode_o.four_line_en, 0);
    busy_len(c, E);
    u_host.send(8'h20, c);
    chk("one_line", mode_o.two_line_sel, 0);
    u_host.send(8'h14, c);
    chk("addr_one_line", address_counter_o, 7'h21);
    @(posedge core_clk_i);
    expander_present_i <= 1'b0;
    repeat (6) @(posedge core_clk_i);
    #1;
    chk("div_one_line", clock_div_o, lcd_instruction_decoder_pkg::ONE_LINE_DIV);
  endtask

  always @(posedge core_clk_i) begin
    ticks++;
    if (display_shift_o === 1'b1) begin
      n_shift++;
    end
    if (ticks == 98000) begin
      err_total++;
      report_and_stop();
    end
  end

  initial begin
    err_total          = 0;
    n_checks           = 0;
    ticks              = 0;
    n_shift            = 0;
    reset_i            = 1'b1;
    expander_present_i = 1'b1;
    cursor_inc_i       = 1'b0;
    t_reset();
    t_two_line();
    t_glyph();
    t_extended();
    t_four_line();
    t_low_power();
    report_and_stop();
  end
endmodule
